//--- msq_core.sv
/*
 * Microsequencer next-state core: microcode store, pipeline register,
 * stack, loop down-counter and master reset sequencing.
 * Assumes a 20 MHz clock, inputs synchronous to it, and external
 * product-term logic that supplies the three multiway conditions.
 */
// Notes on behaviour
// - Stack holds fifteen eight-bit entries
// - Top entry feeds next address or counter
// - Push constant field or counter value
// - Push sampled input pins onto stack
// - Push and pop on rising edge
// - Pop from empty stack yields zero
// - Full push overwrites only top entry
// - Counter loads from constant or top
// - Counter changes on edge, never wraps
// - Zero flag set when counter is zero
// - Output enable bit passed out on user_oe_o; outputs always driven
// - Valid reset empties stack, clears counter, boots
// - One-edge reset means supervisor; two undefined
// - Boot outputs from fourth edge, release third
// - Jump takes target address
// - Call pushes return, branches to target
// - Return uses top entry and pops it
// - Load counter from constant, then branch
// - Loop on nonzero decrements, else exits
// - Decrement if nonzero, always branch target
// - Thirty-six bit microword field layout
// - Next address from target, alternate, or top
// - Above 191, pick one of four words
`timescale 1ns/1ps
module msq_core (
  input  wire logic                           core_clk_i,
  input  wire logic                           srst_i,
  input  wire logic                           master_reset_low_i,
  input  wire logic [msq_pkg::DATA_WIDTH-1:0] branch_inputs_i,
  input  wire logic [2:0]                     branch_cond_i,
  input  wire msq_pkg::msq_prog_type          prog_i,
  output logic      [msq_pkg::USER_WIDTH-1:0] user_out_o,
  output logic                                user_oe_o,
  output logic      [msq_pkg::ADDR_WIDTH-1:0] state_addr_o,
  output logic      [1:0]                     state_way_o,
  output logic      [msq_pkg::DATA_WIDTH-1:0] loop_down_counter_o,
  output logic                                zero_flag_o,
  output logic      [3:0]                     stack_depth_o,
  output logic                                short_reset_o
);
  import msq_pkg::*;

  msq_word_type          ucode_r [MEM_WORDS];
  msq_word_type          pipe_r;
  logic [ADDR_WIDTH-1:0] addr_r;
  logic [1:0]            way_r;
  logic [DATA_WIDTH-1:0] count_r;
  logic                  zero_r;
  logic [1:0]            low_cnt_r;
  logic [1:0]            rel_cnt_r;
  logic                  short_r;
  msq_mode_type          mode_r;

  logic [DATA_WIDTH-1:0] stack_top;
  logic [3:0]            stack_depth;

  // Decode of the current microword
  wire [2:0] opcode_field = pipe_r.opcode;
  wire is_jump  = (opcode_field == OP_JUMP);
  wire is_call  = (opcode_field == OP_CALL);
  wire is_ret   = (opcode_field == OP_RETURN);
  wire is_load_counter_op = (opcode_field == OP_LOAD_COUNTER);
  wire is_loop  = (opcode_field == OP_LOOP_NONZERO);
  wire is_dec   = (opcode_field == OP_DEC_NONZERO);
  wire is_pushi = (opcode_field == OP_PUSH_INPUTS);
  wire is_popc  = (opcode_field == OP_POP_COUNTER);

  wire count_zero = (count_r == COUNT_ZERO);

  // Address multiplexer
  wire [ADDR_WIDTH-1:0] next_addr =
      is_ret                  ? stack_top :
      (is_loop && !count_zero) ? pipe_r.alt :
      pipe_r.target;

  // Prioritised way select, off below the multiway region
  wire       multiway = (next_addr >= MULTIWAY_BASE);
  wire [1:0] cond_way = branch_cond_i[2] ? 2'h3 :
                        branch_cond_i[1] ? 2'h2 :
                        branch_cond_i[0] ? 2'h1 : 2'h0;
  wire [1:0] next_way = multiway ? cond_way : 2'h0;

  wire [MEM_IDX_WIDTH-1:0] mw_offset = {1'b0, next_addr - MULTIWAY_BASE};
  wire [MEM_IDX_WIDTH-1:0] fetch_idx = multiway
      ? MULTIWAY_IDX + {mw_offset[6:0], next_way}
      : {1'b0, next_addr};
  wire msq_word_type fetch_word = ucode_r[fetch_idx];

  // Stack control; a zero mask on the input push selects the counter instead
  wire                  push_cnt   = is_pushi && (pipe_r.alt == PUSH_COUNT_MASK);
  wire                  stk_push   = is_call || is_pushi;
  wire                  stk_pop    = is_ret || is_popc;
  wire [DATA_WIDTH-1:0] push_data  =
      is_call  ? pipe_r.alt :
      push_cnt ? count_r :
      (branch_inputs_i & pipe_r.alt);

  // Loop down-counter next value
  wire [DATA_WIDTH-1:0] count_dec = count_zero ? COUNT_ZERO : count_r - COUNT_STEP;
  wire [DATA_WIDTH-1:0] count_step =
      is_load_counter_op            ? pipe_r.alt :
      is_popc             ? stack_top :
      (is_loop || is_dec) ? count_dec :
      count_r;

  // Master reset sequencing
  wire rst_low     = !master_reset_low_i;
  wire enter_boot  = rst_low && (low_cnt_r == RST_ARM_EDGES) && (mode_r == SEQ_RUN);
  wire in_boot     = (mode_r == SEQ_BOOT);
  wire leave_boot  = in_boot && !rst_low && (rel_cnt_r == RST_HOLD_EDGES);
  wire hold_boot   = in_boot && !leave_boot;
  wire step        = (mode_r == SEQ_RUN && !enter_boot) || leave_boot;
  wire short_pulse = !rst_low && (mode_r == SEQ_RUN) && (low_cnt_r != RST_EDGES_NONE);
  wire stk_clear   = enter_boot || hold_boot;

  wire [1:0] low_cnt_nxt = !rst_low ? RST_EDGES_NONE :
                           (low_cnt_r == RST_SAT_EDGES) ? low_cnt_r : low_cnt_r + RST_EDGE_STEP;
  wire [1:0] rel_cnt_nxt = (rst_low || !in_boot) ? RST_EDGES_NONE :
                           (rel_cnt_r == RST_SAT_EDGES) ? rel_cnt_r : rel_cnt_r + RST_EDGE_STEP;
  wire [DATA_WIDTH-1:0] count_nxt = stk_clear ? COUNT_RESET : step ? count_step : count_r;

  msq_stack u_stack (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .clear_i     (stk_clear),
    .push_i      (step && stk_push),
    .pop_i       (step && stk_pop),
    .push_data_i (push_data),
    .top_o       (stack_top),
    .depth_o     (stack_depth)
  );

  // Microcode store, written by the loader; not reset
  always_ff @(posedge core_clk_i) begin
    if (prog_i.we && prog_i.idx < MEM_IDX_WIDTH'(MEM_WORDS)) begin
      ucode_r[prog_i.idx] <= prog_i.word;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mode_r    <= SEQ_RUN;
      low_cnt_r <= RST_EDGES_NONE;
      rel_cnt_r <= RST_EDGES_NONE;
      short_r   <= 1'b0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      rel_cnt_r <= rel_cnt_nxt;
      if (enter_boot) begin
        mode_r <= SEQ_BOOT;
      end else if (leave_boot) begin
        mode_r <= SEQ_RUN;
      end
      if (enter_boot) begin
        short_r <= 1'b0;
      end else if (short_pulse) begin
        short_r <= 1'b1;
      end
    end
  end

  // Pipeline register; boot word reloaded every edge while boot is held
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pipe_r <= '0;
      addr_r <= BOOT_ADDR;
      way_r  <= 2'h0;
    end else if (hold_boot) begin
      pipe_r <= ucode_r[BOOT_IDX];
      addr_r <= BOOT_ADDR;
      way_r  <= 2'h0;
    end else if (step) begin
      pipe_r <= fetch_word;
      addr_r <= next_addr;
      way_r  <= next_way;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count_r <= COUNT_RESET;
      zero_r  <= 1'b1;
    end else begin
      count_r <= count_nxt;
      zero_r  <= (count_nxt == COUNT_ZERO);
    end
  end

  assign user_out_o          = pipe_r.user;
  assign user_oe_o           = pipe_r.oe;
  assign state_addr_o        = addr_r;
  assign state_way_o         = way_r;
  assign loop_down_counter_o = count_r;
  assign zero_flag_o         = zero_r;
  assign stack_depth_o       = stack_depth;
  assign short_reset_o       = short_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_run_op(logic [2:0] op);
    mode_r == SEQ_RUN && !enter_boot && !rst_low && opcode_field == op;
  endsequence

  sequence s_valid_reset;
    rst_low [*3];
  endsequence

  a_zero_flag_match : assert property (zero_flag_o == (loop_down_counter_o == 8'h00))
    else $error("zero flag disagrees with counter");

  a_counter_no_wrap : assert property (
    $past(count_r) == 8'h00 && !$past(is_load_counter_op || is_popc) |-> count_r == 8'h00)
    else $error("counter wrapped below zero");

  a_load_counter_op_loads : assert property (s_run_op(OP_LOAD_COUNTER) |=>
    count_r == $past(pipe_r.alt) && addr_r == $past(pipe_r.target))
    else $error("load counter did not load constant");

  a_return_pops : assert property (s_run_op(OP_RETURN) ##0 stack_depth != 4'h0 |=>
    addr_r == $past(stack_top) && stack_depth == $past(stack_depth) - 4'h1)
    else $error("return did not use and pop top");

  a_call_pushes : assert property (s_run_op(OP_CALL) |=>
    stack_top == $past(pipe_r.alt) && addr_r == $past(pipe_r.target))
    else $error("call did not push return address");

  a_jump_target : assert property (s_run_op(OP_JUMP) |=>
    addr_r == $past(pipe_r.target) && count_r == $past(count_r))
    else $error("jump went astray");

  a_loop_nonzero : assert property (s_run_op(OP_LOOP_NONZERO) ##0 !count_zero |=>
    addr_r == $past(pipe_r.alt) && count_r == $past(count_r) - 8'h01)
    else $error("loop did not branch and decrement");

  a_loop_exit : assert property (s_run_op(OP_LOOP_NONZERO) ##0 count_zero |=>
    addr_r == $past(pipe_r.target) && count_r == 8'h00)
    else $error("loop exit wrong");

  a_dec_nonzero : assert property (s_run_op(OP_DEC_NONZERO) ##0 !count_zero |=>
    count_r == $past(count_r) - 8'h01 && addr_r == $past(pipe_r.target))
    else $error("decrement if nonzero wrong");

  a_boot_reset : assert property (mode_r == SEQ_RUN ##0 s_valid_reset |=>
    stack_depth == 4'h0 && count_r == 8'h00 ##1 addr_r == 8'h00)
    else $error("valid reset did not boot");

  a_boot_hold : assert property (in_boot && !rst_low && rel_cnt_r != RST_HOLD_EDGES |=>
    addr_r == 8'h00 && pipe_r == ucode_r[0])
    else $error("boot word not held after release");

  a_short_flag : assert property (
    mode_r == SEQ_RUN && !rst_low ##1 rst_low ##1 !rst_low |=> short_reset_o)
    else $error("one edge reset not flagged");

  a_multiway_off : assert property (
    step && !hold_boot && next_addr < 8'hC0 |=> state_way_o == 2'h0)
    else $error("way select below multiway region");

  // Stack, counter, boot and multiway checks
  a_popc_loads : assert property (s_run_op(OP_POP_COUNTER) |=>
    count_r == $past(stack_top) && addr_r == $past(pipe_r.target))
    else $error("pop into counter wrong");

  a_push_masked : assert property (s_run_op(OP_PUSH_INPUTS) ##0 pipe_r.alt != 8'h00 |=>
    stack_top == ($past(branch_inputs_i) & $past(pipe_r.alt)))
    else $error("masked input push wrong");

  a_push_counter : assert property (s_run_op(OP_PUSH_INPUTS) ##0 pipe_r.alt == 8'h00 |=>
    stack_top == $past(count_r))
    else $error("counter push wrong");

  a_call_depth : assert property (s_run_op(OP_CALL) ##0 stack_depth != 4'hF |=>
    stack_depth == $past(stack_depth) + 4'h1)
    else $error("call did not deepen stack");

  a_jump_stack : assert property (s_run_op(OP_JUMP) |=>
    stack_depth == $past(stack_depth))
    else $error("jump touched the stack");

  a_boot_entry : assert property (enter_boot ##1 rst_low |=>
    addr_r == 8'h00 && pipe_r == ucode_r[0])
    else $error("boot word missing on fourth edge");

  a_multiway_pick : assert property (
    step && !hold_boot && next_addr >= 8'hC0 && branch_cond_i[2] |=> state_way_o == 2'h3)
    else $error("highest condition not chosen");

  a_short_no_boot : assert property (short_pulse |=>
    mode_r == SEQ_RUN && short_reset_o)
    else $error("short reset changed mode");

  a_load_counter_op_zero : assert property (s_run_op(OP_LOAD_COUNTER) |=>
    zero_flag_o == ($past(pipe_r.alt) == 8'h00))
    else $error("zero flag wrong after load");

endmodule

//--- msq_pkg.sv
/*
 * Shared constants, microword layout and types for the microsequencer core.
 * Assumes a single 20 MHz core clock and an external microcode loader.
 */
package msq_pkg;

  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          USER_WIDTH       = 16;
  localparam int          ADDR_WIDTH       = 8;
  localparam int          DATA_WIDTH       = 8;
  localparam int          STACK_DEPTH      = 15;
  localparam int          MEM_WORDS        = 448;
  localparam int          MEM_IDX_WIDTH    = 9;
  localparam logic [3:0]  STACK_FULL_LEVEL = 4'hF;
  localparam logic [7:0]  MULTIWAY_BASE    = 8'hC0;
  localparam logic [8:0]  MULTIWAY_IDX     = 9'h0C0;
  localparam logic [7:0]  BOOT_ADDR        = 8'h00;
  localparam logic [8:0]  BOOT_IDX         = 9'h000;
  localparam logic [7:0]  COUNT_RESET      = 8'h00;
  localparam logic [7:0]  COUNT_ZERO       = 8'h00;
  localparam logic [7:0]  COUNT_STEP       = 8'h01;
  localparam logic [7:0]  PUSH_COUNT_MASK  = 8'h00;

  // Master reset timing, counted in rising edges of the core clock
  localparam logic [1:0]  RST_ARM_EDGES    = 2'h2;
  localparam logic [1:0]  RST_SAT_EDGES    = 2'h3;
  localparam logic [1:0]  RST_HOLD_EDGES   = 2'h2;
  localparam logic [1:0]  RST_EDGE_STEP    = 2'h1;
  localparam logic [1:0]  RST_EDGES_NONE   = 2'h0;

  // Opcode encodings
  localparam logic [2:0]  OP_JUMP          = 3'h0;
  localparam logic [2:0]  OP_CALL          = 3'h1;
  localparam logic [2:0]  OP_RETURN        = 3'h2;
  localparam logic [2:0]  OP_LOAD_COUNTER  = 3'h3;
  localparam logic [2:0]  OP_LOOP_NONZERO  = 3'h4;
  localparam logic [2:0]  OP_DEC_NONZERO   = 3'h5;
  localparam logic [2:0]  OP_PUSH_INPUTS   = 3'h6;
  localparam logic [2:0]  OP_POP_COUNTER   = 3'h7;

  typedef struct packed {
    logic                  oe;
    logic [2:0]            opcode;
    logic [DATA_WIDTH-1:0] alt;
    logic [ADDR_WIDTH-1:0] target;
    logic [USER_WIDTH-1:0] user;
  } msq_word_type;

  typedef struct packed {
    logic                     we;
    logic [MEM_IDX_WIDTH-1:0] idx;
    msq_word_type             word;
  } msq_prog_type;

  typedef enum logic {SEQ_RUN, SEQ_BOOT} msq_mode_type;

endpackage

//--- msq_stack.sv
/*
 * Fifteen-entry, eight-bit last-in first-out stack, zero filled.
 * Assumes push and pop are never requested in the same cycle.
 */
`timescale 1ns/1ps
module msq_stack (
  input  wire logic                          core_clk_i,
  input  wire logic                          srst_i,
  input  wire logic                          clear_i,
  input  wire logic                          push_i,
  input  wire logic                          pop_i,
  input  wire logic [msq_pkg::DATA_WIDTH-1:0] push_data_i,
  output logic      [msq_pkg::DATA_WIDTH-1:0] top_o,
  output logic      [3:0]                    depth_o
);
  import msq_pkg::*;

  logic [DATA_WIDTH-1:0] entry_r [STACK_DEPTH];
  logic [3:0]            depth_r;
  wire                   full = (depth_r == STACK_FULL_LEVEL);

  always_ff @(posedge core_clk_i) begin
    if (srst_i || clear_i) begin
      for (int i = 0; i < STACK_DEPTH; i++) entry_r[i] <= '0;
      depth_r <= '0;
    end else if (push_i) begin
      entry_r[0] <= push_data_i;
      if (!full) begin
        for (int i = 1; i < STACK_DEPTH; i++) entry_r[i] <= entry_r[i-1];
        depth_r <= depth_r + 4'h1;
      end
    end else if (pop_i) begin
      // Zero fill from the bottom keeps an empty pop reading zero
      for (int i = 0; i < STACK_DEPTH - 1; i++) entry_r[i] <= entry_r[i+1];
      entry_r[STACK_DEPTH-1] <= '0;
      if (depth_r != 4'h0) depth_r <= depth_r - 4'h1;
    end
  end

  assign top_o   = entry_r[0];
  assign depth_o = depth_r;

  a_full_push_keeps : assert property (@(posedge core_clk_i) disable iff (srst_i)
    full && push_i && !clear_i |=> depth_r == STACK_FULL_LEVEL
      && entry_r[1] == $past(entry_r[1]) && entry_r[14] == $past(entry_r[14]))
    else $error("full push disturbed lower entries");

  a_empty_pop_zero : assert property (@(posedge core_clk_i) disable iff (srst_i)
    depth_r == 4'h0 && pop_i |=> top_o == '0 && depth_r == 4'h0)
    else $error("pop of empty stack not zero");

endmodule

//--- msq_far_side.sv
/*
 * Model of the system logic outside the sequencer core: master reset pin,
 * eight branch inputs and the three ready-made multiway conditions.
 * Assumes the testbench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps
module msq_far_side (
  input  wire logic                          core_clk_i,
  output logic                               master_reset_low_o,
  output logic      [msq_pkg::DATA_WIDTH-1:0] branch_inputs_o,
  output logic      [2:0]                    branch_cond_o
);
  import msq_pkg::*;

  initial begin
    master_reset_low_o = 1'b1;
    branch_inputs_o    = 8'h00;
    branch_cond_o      = 3'h0;
  end

  // Level only; the caller counts edges so short pulses can be made on purpose
  task automatic set_reset(input logic lvl);
    master_reset_low_o = lvl;
  endtask

  task automatic set_inputs(input logic [7:0] bi, input logic [2:0] bc);
    branch_inputs_o = bi;
    branch_cond_o   = bc;
  endtask
endmodule

//--- msq_core_tb_top.sv
/*
 * Self-checking testbench for the sequencer core: loads a small microprogram,
 * walks calls, loops, stack overflow and underflow, multiway and resets.
 * Assumes the far-side model drives the reset pin and branch inputs.
 */
`timescale 1ns/1ps
module msq_core_tb_top;
  import msq_pkg::*;
  logic         core_clk;
  logic         srst;
  logic         mrst_n;
  logic  [7:0]  bin;
  logic  [2:0]  bcond;
  msq_prog_type prog;
  logic  [15:0] user;
  logic         oe;
  logic  [7:0]  addr;
  logic  [1:0]  way;
  logic  [7:0]  cnt;
  logic         zf;
  logic  [3:0]  depth;
  logic         shrt;
  int           err_count;
  int           comparisons;
  logic  [7:0]  q[$];
  logic  [7:0]  v;

  msq_far_side u_far (.core_clk_i(core_clk), .master_reset_low_o(mrst_n),
    .branch_inputs_o(bin), .branch_cond_o(bcond));
  msq_core u_dut (.core_clk_i(core_clk), .srst_i(srst), .master_reset_low_i(mrst_n),
    .branch_inputs_i(bin), .branch_cond_i(bcond), .prog_i(prog), .user_out_o(user),
    .user_oe_o(oe), .state_addr_o(addr), .state_way_o(way), .loop_down_counter_o(cnt),
    .zero_flag_o(zf), .stack_depth_o(depth), .short_reset_o(shrt));

  always #25 core_clk = ~core_clk;

  function automatic msq_word_type w(input logic e, input logic [2:0] op,
                                     input logic [7:0] alt, input logic [7:0] tgt);
    w = {e, op, alt, tgt, tgt, tgt};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ld(input logic [8:0] i, input msq_word_type wd);
    prog = '{we: 1'b1, idx: i, word: wd};
    @(posedge core_clk);
    #1;
  endtask

  task automatic step(input logic [7:0] a, input logic [7:0] c, input logic [3:0] d);
    @(posedge core_clk);
    #1;
    chk(16'(addr), 16'(a));
    chk(16'(cnt), 16'(c));
    chk(16'(zf), 16'(c == 8'h00));
    chk(16'(depth), 16'(d));
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 100 cycles the sequence needs
  initial begin
    repeat (2000) @(posedge core_clk);
    err_count++;
    close_out();
  end

  initial begin
    core_clk    = 1'b0;
    srst        = 1'b1;
    err_count   = 0;
    comparisons = 0;
    // First fetched words go in while reset holds, so the core never runs unknown words
    ld(9'h000, w(1'b1, OP_LOAD_COUNTER, 8'h02, 8'h01));
    ld(9'h001, w(1'b1, OP_CALL, 8'h03, 8'h0A));
    ld(9'h00A, w(1'b0, OP_DEC_NONZERO, 8'h00, 8'h0B));
    ld(9'h00B, w(1'b1, OP_PUSH_INPUTS, 8'h00, 8'h0C));
    ld(9'h00C, w(1'b1, OP_POP_COUNTER, 8'h00, 8'h0D));
    srst = 1'b0;
    chk(16'(zf), 16'h0001);
    chk(16'(depth), 16'h0000);
    chk(16'(shrt), 16'h0000);
    ld(9'h00D, w(1'b1, OP_RETURN, 8'h00, 8'h00));
    ld(9'h003, w(1'b1, OP_LOOP_NONZERO, 8'h03, 8'h04));
    ld(9'h004, w(1'b1, OP_DEC_NONZERO, 8'h00, 8'h05));
    ld(9'h005, w(1'b1, OP_PUSH_INPUTS, 8'hF1, 8'h06));
    ld(9'h006, w(1'b1, OP_RETURN, 8'h00, 8'h00));
    ld(9'h0C7, w(1'b1, OP_JUMP, 8'h00, 8'h07));
    ld(9'h007, w(1'b1, OP_LOAD_COUNTER, 8'h10, 8'h14));
    ld(9'h014, w(1'b1, OP_PUSH_INPUTS, 8'hFF, 8'h15));
    ld(9'h015, w(1'b1, OP_LOOP_NONZERO, 8'h14, 8'h16));
    ld(9'h016, w(1'b1, OP_POP_COUNTER, 8'h00, 8'h16));
    prog.we = 1'b0;
    // Program looped from word 0 while loading; a full master reset restarts it
    u_far.set_reset(1'b0);
    repeat (3) @(posedge core_clk);
    #1;
    chk(16'(cnt), 16'h0000);
    chk(16'(depth), 16'h0000);
    step(8'h00, 8'h00, 4'h0);
    step(8'h00, 8'h00, 4'h0);
    u_far.set_reset(1'b1);
    step(8'h00, 8'h00, 4'h0);
    step(8'h00, 8'h00, 4'h0);
    chk(user, 16'h0101);
    chk(16'(oe), 16'h0001);
    step(8'h01, 8'h02, 4'h0);
    u_far.set_inputs(8'hC5, 3'b101);
    step(8'h0A, 8'h02, 4'h1);
    chk(16'(oe), 16'h0000);
    chk(16'(u_dut.user_out_o), 16'h0B0B);
    step(8'h0B, 8'h01, 4'h1);
    step(8'h0C, 8'h01, 4'h2);
    step(8'h0D, 8'h01, 4'h1);
    step(8'h03, 8'h01, 4'h0);
    step(8'h03, 8'h00, 4'h0);
    step(8'h04, 8'h00, 4'h0);
    step(8'h05, 8'h00, 4'h0);
    step(8'h06, 8'h00, 4'h1);
    step(8'hC1, 8'h00, 4'h0);
    chk(16'(way), 16'h0003);
    step(8'h07, 8'h00, 4'h0);
    step(8'h14, 8'h10, 4'h0);
    // Seventeen pushes into fifteen places: the last two land on the top
    for (int i = 0; i < 17; i++) begin
      v = 8'(8'h30 + i);
      u_far.set_inputs(v, 3'b000);
      if (q.size() == 15) q[14] = v;
      else q.push_back(v);
      step(8'h15, 8'(16 - i), 4'(q.size()));
      step((i < 16) ? 8'h14 : 8'h16, (i < 16) ? 8'(15 - i) : 8'h00, 4'(q.size()));
    end
    for (int j = 0; j < 16; j++) begin
      v = (q.size() > 0) ? q.pop_back() : 8'h00;
      step(8'h16, v, 4'(q.size()));
    end
    u_far.set_reset(1'b0);
    step(8'h16, 8'h00, 4'h0);
    u_far.set_reset(1'b1);
    step(8'h16, 8'h00, 4'h0);
    chk(16'(shrt), 16'h0001);
    u_far.set_reset(1'b0);
    repeat (5) @(posedge core_clk);
    #1;
    u_far.set_reset(1'b1);
    step(8'h00, 8'h00, 4'h0);
    step(8'h00, 8'h00, 4'h0);
    step(8'h01, 8'h02, 4'h0);
    chk(16'(shrt), 16'h0000);
    close_out();
  end
endmodule
